// >>> hdl/rtc_time_pkg.sv
// Constants and types for the timekeeping register bank
// Behaviour
// [RULE1] Sub-second register: tenths high, hundredths low BCD
// [RULE2] Seconds BCD 00-59, three-bit tens field
// [RULE3] Top seconds bit starts/stops the oscillator
// [RULE4] Boot variant: top seconds bit starts counting
// [RULE5] Minutes BCD 00-59, top bit reads zero
// [RULE6] Format bit: zero 24-hour, one 12-hour
// [RULE7] Hour tens layout differs by format, AM/PM
// [RULE8] Hour top bit selects trim correction sign
// [RULE9] Running flag read-only, hardware driven only
// [RULE10] Running flag set after 32 oscillator cycles
// [RULE11] Supply failure sets the battery-switched flag
// [RULE12] Battery flag cleared only by writing zero
// [RULE13] Battery enable connects backup battery input
// [RULE14] Weekday 1-7 in low bits, top two zero
// [RULE15] 100 Hz count, carries ripple, day 7->1
// [RULE16] Stopping oscillator clears flag, freezes counters
package rtc_time_pkg;
    localparam logic [7:0] ADDR_SUBSEC   = 8'h00;
    localparam logic [7:0] ADDR_SECONDS  = 8'h01;
    localparam logic [7:0] ADDR_MINUTES  = 8'h02;
    localparam logic [7:0] ADDR_HOURS    = 8'h03;
    localparam logic [7:0] ADDR_WEEKDAY  = 8'h04;

    localparam int START_POS    = 7;
    localparam int TRIM_POS     = 7;
    localparam int FORMAT_POS   = 6;
    localparam int AMPM_POS     = 5;
    localparam int RUNNING_POS  = 5;
    localparam int BATFLAG_POS  = 4;
    localparam int BATEN_POS    = 3;

    localparam logic [7:0] RST_SUBSEC  = 8'h00;
    localparam logic [7:0] RST_SECONDS = 8'h00;
    localparam logic [6:0] RST_MINUTES = 7'h00;
    localparam logic [7:0] RST_HOURS   = 8'h00;
    localparam logic [2:0] RST_WEEKDAY = 3'h1;
    localparam logic       RST_BATEN   = 1'b0;

    localparam logic [7:0] MAX_SUBSEC  = 8'h99;
    localparam logic [7:0] MAX_SIXTY   = 8'h59;
    localparam logic [7:0] MAX_HOUR24  = 8'h23;
    localparam logic [7:0] HOUR12_LAST = 8'h12;
    localparam logic [7:0] HOUR12_TURN = 8'h11;
    localparam logic [2:0] LAST_DAY    = 3'h7;

    localparam logic [5:0]  WARMUP_CYCLES = 6'h20;
    localparam logic [15:0] OSC_HZ        = 16'h8000;
    localparam logic [15:0] SUBSEC_HZ     = 16'h0064;

    typedef enum logic [2:0] {
        OSC_STOPPED = 3'b001,
        OSC_WARMUP  = 3'b010,
        OSC_RUNNING = 3'b100
    } osc_state_t;
endpackage : rtc_time_pkg

// >>> hdl/rtc_time_register_bank.sv
// Timekeeping counters and their register bank
`timescale 1ns/10ps
`default_nettype none
module rtc_time_register_bank
    import rtc_time_pkg::*;
#(
    parameter bit BOOT_CLOCK_VARIANT = 1'b0   // One: oscillator free-runs, top bit gates counting
) (
    input  wire logic       clk_in,          // 100 MHz system clock
    input  wire logic       rst_in,          // Synchronous reset, active high
    input  wire logic [7:0] addr_in,         // Register address from the serial engine
    input  wire logic       wr_en_in,        // Write strobe, one cycle
    input  wire logic [7:0] wr_data_in,      // Write data
    output logic      [7:0] rd_data_out,     // Registered read data for addr_in
    input  wire logic       osc_clk_in,      // 32.768 kHz oscillator pin
    input  wire logic       supply_fail_in,  // Main supply failed, pin level
    output logic            osc_enable_out,  // Enables the crystal oscillator
    output logic            trim_sign_out,   // One: negative trim
    output logic            battery_connect_out // Connects the backup battery input
);
    logic       osc_meta, osc_sync, osc_prev, fail_meta, fail_sync;
    logic [7:0] subsec, next_subsec;
    logic [7:0] seconds, next_seconds;
    logic [6:0] minutes, next_minutes;
    logic [7:0] hours, next_hours;
    logic [2:0] weekday, next_weekday;
    logic       battery_flag, next_battery_flag;
    logic       battery_connect_enable, next_battery_connect_enable;
    logic [15:0] phase_acc, next_phase_acc;
    logic [5:0] warm_cnt, next_warm_cnt;
    osc_state_t osc_state, next_osc_state;
    logic [7:0] next_rd_data;

    logic osc_edge, osc_running_flag, count_en, tick;
    logic wr_sub, wr_sec, wr_min, wr_hour, wr_day;
    logic [8:0] sub_inc, sec_inc, min_inc;
    logic [7:0] hour_adv;
    logic [8:0] hour12_inc, hour24_inc;
    logic       hour_carry;

    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] maxv);
        if (v == maxv) begin
            bcd_inc = 9'h100;
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    assign osc_edge         = osc_sync & ~osc_prev;
    assign osc_running_flag = (osc_state == OSC_RUNNING);                       // [RULE9]
    assign osc_enable_out   = BOOT_CLOCK_VARIANT ? 1'b1 : seconds[START_POS];   // [RULE3]
    assign count_en         = osc_running_flag & (BOOT_CLOCK_VARIANT ? seconds[START_POS] : 1'b1); // [RULE4] [RULE16]
    assign tick             = count_en & osc_edge & (next_phase_acc < phase_acc);
    assign trim_sign_out    = hours[TRIM_POS];                                  // [RULE8]
    assign battery_connect_out = battery_connect_enable;                        // [RULE13]

    assign wr_sub  = wr_en_in & (addr_in == ADDR_SUBSEC);
    assign wr_sec  = wr_en_in & (addr_in == ADDR_SECONDS);
    assign wr_min  = wr_en_in & (addr_in == ADDR_MINUTES);
    assign wr_hour = wr_en_in & (addr_in == ADDR_HOURS);
    assign wr_day  = wr_en_in & (addr_in == ADDR_WEEKDAY);

    // Hundredths phase accumulator
    always_comb begin
        next_phase_acc = phase_acc;
        if (count_en && osc_edge) begin
            // Wraps SUBSEC_HZ times per OSC_HZ edges: exact 100 Hz on average
            next_phase_acc = phase_acc + SUBSEC_HZ;                             // [RULE15]
            if (next_phase_acc >= OSC_HZ) begin
                next_phase_acc = next_phase_acc - OSC_HZ;
            end
        end
    end

    // Oscillator state
    always_comb begin
        next_osc_state = osc_state;
        next_warm_cnt  = warm_cnt;
        case (osc_state)
            OSC_STOPPED: begin
                next_warm_cnt = 6'h00;
                if (osc_enable_out) begin
                    next_osc_state = OSC_WARMUP;
                end
            end
            OSC_WARMUP: begin
                if (!osc_enable_out) begin
                    next_osc_state = OSC_STOPPED;
                end else if (osc_edge) begin
                    next_warm_cnt = warm_cnt + 6'h01;
                    if (next_warm_cnt == WARMUP_CYCLES) begin                   // [RULE10]
                        next_osc_state = OSC_RUNNING;
                    end
                end
            end
            OSC_RUNNING: begin
                if (!osc_enable_out) begin
                    next_osc_state = OSC_STOPPED;                               // [RULE16]
                end
            end
            default: begin
                next_osc_state = OSC_STOPPED;
            end
        endcase
    end

    // Time counters and register writes
    always_comb begin
        sub_inc = bcd_inc(subsec, MAX_SUBSEC);                                  // [RULE1]
        sec_inc = bcd_inc({1'b0, seconds[6:0]}, MAX_SIXTY);                     // [RULE2]
        min_inc = bcd_inc({1'b0, minutes}, MAX_SIXTY);                          // [RULE5]
        hour12_inc = bcd_inc({3'b000, hours[4:0]}, HOUR12_LAST);
        hour24_inc = bcd_inc({2'b00, hours[5:0]}, MAX_HOUR24);
        hour_adv   = hours;
        hour_carry = 1'b0;
        if (hours[FORMAT_POS]) begin                                            // [RULE6]
            if ({3'b000, hours[4:0]} == HOUR12_LAST) begin                      // [RULE7]
                hour_adv[4:0] = 5'h01;
            end else if ({3'b000, hours[4:0]} == HOUR12_TURN) begin
                hour_adv[4:0]    = HOUR12_LAST[4:0];
                hour_adv[AMPM_POS] = ~hours[AMPM_POS];
                hour_carry       = hours[AMPM_POS];
            end else begin
                hour_adv[4:0] = hour12_inc[4:0];
            end
        end else begin
            if ({2'b00, hours[5:0]} == MAX_HOUR24) begin                        // [RULE7]
                hour_adv[5:0] = 6'h00;
                hour_carry    = 1'b1;
            end else begin
                hour_adv[5:0] = hour24_inc[5:0];
            end
        end

        next_subsec  = subsec;
        next_seconds = seconds;
        next_minutes = minutes;
        next_hours   = hours;
        next_weekday = weekday;
        if (tick) begin                                                         // [RULE15]
            next_subsec = sub_inc[7:0];
            if (sub_inc[8]) begin
                next_seconds[6:0] = sec_inc[6:0];
                if (sec_inc[8]) begin
                    next_minutes = min_inc[6:0];
                    if (min_inc[8]) begin
                        next_hours = hour_adv;
                        if (hour_carry) begin
                            next_weekday = (weekday == LAST_DAY) ? 3'h1 : weekday + 3'h1;
                        end
                    end
                end
            end
        end
        if (wr_sub) begin
            next_subsec = wr_data_in;                                           // [RULE1]
        end
        if (wr_sec) begin
            next_seconds = wr_data_in;                                          // [RULE3]
        end
        if (wr_min) begin
            next_minutes = wr_data_in[6:0];                                     // [RULE5]
        end
        if (wr_hour) begin
            next_hours = wr_data_in;                                            // [RULE8]
        end
        if (wr_day) begin
            next_weekday = wr_data_in[2:0];                                     // [RULE14]
        end

        next_battery_connect_enable = wr_day ? wr_data_in[BATEN_POS] : battery_connect_enable; // [RULE13]
        // Failure wins over a clearing write in the same cycle
        next_battery_flag = (battery_flag & ~(wr_day & ~wr_data_in[BATFLAG_POS])) | fail_sync; // [RULE11] [RULE12]
    end

    // Read mux
    always_comb begin
        case (addr_in)
            ADDR_SUBSEC:  next_rd_data = subsec;
            ADDR_SECONDS: next_rd_data = seconds;
            ADDR_MINUTES: next_rd_data = {1'b0, minutes};                       // [RULE5]
            ADDR_HOURS:   next_rd_data = hours;
            ADDR_WEEKDAY: next_rd_data = {2'b00, osc_running_flag, battery_flag,
                                          battery_connect_enable, weekday};     // [RULE9] [RULE14]
            default:      next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            osc_meta  <= 1'b0;
            osc_sync  <= 1'b0;
            osc_prev  <= 1'b0;
            fail_meta <= 1'b0;
            fail_sync <= 1'b0;
            subsec    <= RST_SUBSEC;
            seconds   <= RST_SECONDS;
            minutes   <= RST_MINUTES;
            hours     <= RST_HOURS;
            weekday   <= RST_WEEKDAY;
            battery_flag           <= 1'b0;
            battery_connect_enable <= RST_BATEN;
            phase_acc   <= 16'h0000;
            warm_cnt    <= 6'h00;
            osc_state   <= OSC_STOPPED;
            rd_data_out <= 8'h00;
        end else begin
            osc_meta  <= osc_clk_in;
            osc_sync  <= osc_meta;
            osc_prev  <= osc_sync;
            fail_meta <= supply_fail_in;
            fail_sync <= fail_meta;
            subsec    <= next_subsec;
            seconds   <= next_seconds;
            minutes   <= next_minutes;
            hours     <= next_hours;
            weekday   <= next_weekday;
            battery_flag           <= next_battery_flag;
            battery_connect_enable <= next_battery_connect_enable;
            phase_acc   <= next_phase_acc;
            warm_cnt    <= next_warm_cnt;
            osc_state   <= next_osc_state;
            rd_data_out <= next_rd_data;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_minutes_top_zero;
        $past(addr_in) == ADDR_MINUTES |-> rd_data_out[7] == 1'b0;
    endproperty
    a_minutes_top_zero: assert property (p_minutes_top_zero) else $error("Minutes top bit read nonzero"); // [RULE5]

    property p_weekday_read;
        $past(addr_in) == ADDR_WEEKDAY |-> rd_data_out[7:6] == 2'b00 && rd_data_out[RUNNING_POS] == $past(osc_running_flag);
    endproperty
    a_weekday_read: assert property (p_weekday_read) else $error("Weekday register read wrong"); // [RULE14] [RULE9]

    property p_warmup_done;
        osc_state == OSC_WARMUP && osc_enable_out && osc_edge && warm_cnt == WARMUP_CYCLES - 6'h01
            |=> osc_running_flag;
    endproperty
    a_warmup_done: assert property (p_warmup_done) else $error("Running flag not set after warm-up"); // [RULE10]

    property p_running_only_from_warmup;
        $rose(osc_running_flag) |-> $past(osc_state) == OSC_WARMUP && $past(warm_cnt) == WARMUP_CYCLES - 6'h01;
    endproperty
    a_running_only_from_warmup: assert property (p_running_only_from_warmup) else $error("Running flag set early"); // [RULE10]

    property p_fail_sets_flag;
        fail_sync |=> battery_flag;
    endproperty
    a_fail_sets_flag: assert property (p_fail_sets_flag) else $error("Battery flag not set on failure"); // [RULE11]

    property p_flag_clear_by_write;
        $fell(battery_flag) |-> $past(wr_day && !wr_data_in[BATFLAG_POS] && !fail_sync);
    endproperty
    a_flag_clear_by_write: assert property (p_flag_clear_by_write) else $error("Battery flag cleared by hardware"); // [RULE12]

    property p_stop_clears_running;
        // Enable drops at the write edge, the state follows one edge later
        !BOOT_CLOCK_VARIANT && wr_sec && !wr_data_in[START_POS] |=> ##1 !osc_running_flag ##1 !osc_running_flag;
    endproperty
    a_stop_clears_running: assert property (p_stop_clears_running) else $error("Running flag kept after stop"); // [RULE16]

    property p_frozen;
        !count_en && !wr_sub |=> $stable(subsec);
    endproperty
    a_frozen: assert property (p_frozen) else $error("Counter moved while stopped"); // [RULE16]

    property p_subsec_wrap;
        tick && subsec == MAX_SUBSEC && !wr_sub && !wr_sec && seconds[6:0] == 7'h59
            |=> subsec == 8'h00 && seconds[6:0] == 7'h00;
    endproperty
    a_subsec_wrap: assert property (p_subsec_wrap) else $error("Sub-second carry wrong"); // [RULE15]
endmodule : rtc_time_register_bank
`default_nettype wire

// >>> tb/crystal_model.sv
// Crystal model that drives the oscillator pin while the device enables it
`timescale 1ns/10ps
`default_nettype none
module crystal_model #(
    parameter int HALF_NS = 50   // Shortened half period keeps the run short
) (
    input  wire logic enable_in, // Oscillator enable from the device
    output var  logic osc_out    // Oscillator waveform
);
    initial begin
        osc_out = 1'b0;
        forever begin
            #(HALF_NS);
            // A stopped crystal stands still at low level
            if (enable_in) osc_out = ~osc_out; else osc_out = 1'b0;
        end
    end
endmodule : crystal_model
`default_nettype wire

// >>> tb/tb_rtc_time_register_bank.sv
// Self-checking testbench for the timekeeping register bank
`timescale 1ns/10ps
`default_nettype none
module tb_rtc_time_register_bank;
    import rtc_time_pkg::*;
    logic       clk_in;
    logic       rst_in;
    logic [7:0] addr_in;
    logic       wr_en_in;
    logic [7:0] wr_data_in;
    logic [7:0] rd_data_out;
    logic       osc_clk;
    logic       supply_fail_in;
    logic       osc_enable_out;
    logic       boot_osc_en;
    logic [7:0] boot_rd_data;
    logic       trim_sign_out;
    logic       battery_connect_out;
    int         err_count = 0;
    int         total_checks = 0;
    int         cycles = 0;
    logic [7:0] rst_exp [0:5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] wr_val [0:4]  = '{8'h99, 8'h59, 8'hc5, 8'hd2, 8'hff};
    logic [7:0] rd_exp [0:4]  = '{8'h99, 8'h59, 8'h45, 8'hd2, 8'h0f};
    logic [7:0] roll_exp [0:4] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h29};

    rtc_time_register_bank rtc_time_register_bank_i (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
        .wr_data_in(wr_data_in), .rd_data_out(rd_data_out), .osc_clk_in(osc_clk),
        .supply_fail_in(supply_fail_in), .osc_enable_out(osc_enable_out),
        .trim_sign_out(trim_sign_out), .battery_connect_out(battery_connect_out));
    rtc_time_register_bank #(.BOOT_CLOCK_VARIANT(1'b1)) rtc_time_register_bank_boot_i (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
        .wr_data_in(wr_data_in), .rd_data_out(boot_rd_data), .osc_clk_in(osc_clk),
        .supply_fail_in(supply_fail_in), .osc_enable_out(boot_osc_en),
        .trim_sign_out(), .battery_connect_out());
    crystal_model crystal_model_i (.enable_in(osc_enable_out), .osc_out(osc_clk));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // Hang guard: the sequence needs about 13000 cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_in    = a;
        wr_data_in = d;
        wr_en_in   = 1'b1;
        @(posedge clk_in);
        #1;
        wr_en_in   = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        #1;
        addr_in = a;
        repeat (2) @(posedge clk_in);
        #1;
        check8(what, exp, rd_data_out);
    endtask : rd

    initial begin
        rst_in = 1'b1;
        addr_in = 8'h00;
        wr_en_in = 1'b0;
        wr_data_in = 8'h00;
        supply_fail_in = 1'b0;
        repeat (16) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        for (int i = 0; i < 6; i++)
            rd(i[7:0], rst_exp[i], "reset value");
        check8("osc enable", 8'h00, {7'h00, osc_enable_out});
        check8("boot osc enable", 8'h01, {7'h00, boot_osc_en});
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            wr(i[7:0], wr_val[i]);
            rd(i[7:0], rd_exp[i], "write readback");
        end
        check8("trim sign", 8'h01, {7'h00, trim_sign_out});
        check8("battery connect", 8'h01, {7'h00, battery_connect_out});
        wr(ADDR_HOURS, 8'h23);
        check8("trim sign", 8'h00, {7'h00, trim_sign_out});
        $display("test access done");
        @(posedge clk_in);
        #1;
        supply_fail_in = 1'b1;
        repeat (4) @(posedge clk_in);
        #1;
        supply_fail_in = 1'b0;
        rd(ADDR_WEEKDAY, 8'h1f, "battery flag set");
        repeat (20) @(posedge clk_in);
        rd(ADDR_WEEKDAY, 8'h1f, "battery flag held");
        wr(ADDR_WEEKDAY, 8'h1f);
        rd(ADDR_WEEKDAY, 8'h1f, "battery flag write one");
        wr(ADDR_WEEKDAY, 8'h0f);
        rd(ADDR_WEEKDAY, 8'h0f, "battery flag cleared");
        $display("test supply done");
        wr(ADDR_MINUTES, 8'h59);
        wr(ADDR_SUBSEC, 8'h99);
        wr(ADDR_SECONDS, 8'hd9);
        check8("osc enable", 8'h01, {7'h00, osc_enable_out});
        repeat (200) @(posedge clk_in);
        rd(ADDR_WEEKDAY, 8'h0f, "running flag early");
        repeat (200) @(posedge clk_in);
        rd(ADDR_WEEKDAY, 8'h2f, "running flag set");
        repeat (4600) @(posedge clk_in);
        for (int i = 0; i < 5; i++)
            rd(i[7:0], roll_exp[i], "full rollover");
        check8("boot rollover weekday", 8'h29, boot_rd_data);
        wr(ADDR_SUBSEC, 8'h99);
        wr(ADDR_MINUTES, 8'h59);
        wr(ADDR_SECONDS, 8'hd9);
        wr(ADDR_HOURS, 8'h51);
        repeat (3500) @(posedge clk_in);
        rd(ADDR_HOURS, 8'h72, "twelve hour noon");
        rd(ADDR_WEEKDAY, 8'h29, "day kept at noon");
        $display("test counting done");
        wr(ADDR_SECONDS, 8'h00);
        check8("osc enable", 8'h00, {7'h00, osc_enable_out});
        rd(ADDR_WEEKDAY, 8'h09, "running flag cleared");
        check8("boot running kept", 8'h29, boot_rd_data);
        wr(ADDR_SUBSEC, 8'h55);
        repeat (4000) @(posedge clk_in);
        rd(ADDR_SUBSEC, 8'h55, "frozen subsecond");
        check8("boot frozen subsecond", 8'h55, boot_rd_data);
        rd(ADDR_HOURS, 8'h72, "frozen hour");
        check8("boot osc enable", 8'h01, {7'h00, boot_osc_en});
        $display("test stop done");
        complete_run();
    end
endmodule : tb_rtc_time_register_bank
`default_nettype wire
